//--- include/iepr_pkg.sv
/*
  Package for the interrupt flag, enable and priority register block.
  Assumes a 32-bit APB slave with 16-bit registers in the low half of each word.
*/
package iepr_pkg;
  localparam int NUM_SRC  = 21;
  localparam int PRIO_W   = 3;
  localparam int ADDR_W   = 8;

  // Register byte addresses
  localparam logic [7:0] OFF_FLAG0 = 8'h00;
  localparam logic [7:0] OFF_FLAG1 = 8'h04;
  localparam logic [7:0] OFF_FLAG4 = 8'h08;
  localparam logic [7:0] OFF_EN0   = 8'h10;
  localparam logic [7:0] OFF_EN1   = 8'h14;
  localparam logic [7:0] OFF_EN4   = 8'h18;
  localparam logic [7:0] OFF_PRI0  = 8'h20;
  localparam logic [7:0] OFF_PRI1  = 8'h24;
  localparam logic [7:0] OFF_PRI2  = 8'h28;
  localparam logic [7:0] OFF_PRI3  = 8'h2C;
  localparam logic [7:0] OFF_PRI4  = 8'h30;
  localparam logic [7:0] OFF_PRI5  = 8'h34;
  localparam logic [7:0] OFF_PRI7  = 8'h38;
  localparam logic [7:0] OFF_PRI16 = 8'h3C;

  // Implemented-bit masks of the 16-bit registers
  localparam logic [15:0] MASK_FLAG0 = 16'h3FEF;
  localparam logic [15:0] MASK_FLAG1 = 16'h20DB;
  localparam logic [15:0] MASK_FLAG4 = 16'h0002;

  localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h4;
  localparam logic [PRIO_W-1:0] PRIO_OFF   = 3'h0;

  // Source index: bit position of each source in the concatenated flag vector
  // Indices 0..12 from register 0 bits 0..13 except bit 4, then register 1, then register 4
  localparam int SRC_EXT0 = 0;
  localparam int SRC_CAP1 = 1;
  localparam int SRC_CMP1 = 2;
  localparam int SRC_TMR1 = 3;
  localparam int SRC_CAP2 = 4;
  localparam int SRC_CMP2 = 5;
  localparam int SRC_TMR2 = 6;
  localparam int SRC_TMR3 = 7;
  localparam int SRC_SPIE = 8;
  localparam int SRC_SPI  = 9;
  localparam int SRC_RX   = 10;
  localparam int SRC_TX   = 11;
  localparam int SRC_ADC  = 12;
  localparam int SRC_I2CS = 13;
  localparam int SRC_I2CM = 14;
  localparam int SRC_CHG  = 15;
  localparam int SRC_EXT1 = 16;
  localparam int SRC_CAP7 = 17;
  localparam int SRC_CAP8 = 18;
  localparam int SRC_EXT2 = 19;
  localparam int SRC_SERR = 20;

  typedef struct packed {
    logic              req;
    logic [PRIO_W-1:0] level;
  } iepr_req_t;

  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } iepr_apb_req_t;
endpackage

//--- hdl/iepr_src_cell.sv
/*
  One interrupt source: sticky flag, enable bit and request qualification.
  Assumes set pulses from the peripheral and write strobes from the register file.
*/
module iepr_src_cell (
  // Clock and reset
  input  wire logic                           core_clk,
  input  wire logic                           reset,
  // Peripheral event
  input  wire logic                           evtSet,
  // Software writes
  input  wire logic                           flagWr,
  input  wire logic                           flagWrVal,
  input  wire logic                           enWr,
  input  wire logic                           enWrVal,
  input  wire logic [iepr_pkg::PRIO_W-1:0]    prio,
  // State and request
  output logic                                flag,
  output logic                                enable,
  output iepr_pkg::iepr_req_t                 request
);
  import iepr_pkg::*;

  logic flag_q;
  logic enable_q;

  // Event wins over a same-cycle clear, regardless of enable
  always_ff @(posedge core_clk) begin
    if (reset) begin
      flag_q <= 1'b0;
    end else if (evtSet) begin
      flag_q <= 1'b1;
    end else if (flagWr) begin
      flag_q <= flagWrVal;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      enable_q <= 1'b0;
    end else if (enWr) begin
      enable_q <= enWrVal;
    end
  end

  assign flag   = flag_q;
  assign enable = enable_q;

  always_comb begin
    request.req   = flag_q && enable_q && (prio != PRIO_OFF);
    request.level = request.req ? prio : PRIO_OFF;
  end
endmodule

//--- hdl/iepr_apb_slave.sv
/*
  APB slave front end: zero-wait answer, decodes access strobes.
  Assumes an APB master that holds a request until pready.
*/
module iepr_apb_slave (
  // APB
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic                        pslverr,
  // Register side
  input  wire logic                   addrHit,
  output iepr_pkg::iepr_apb_req_t     busReq,
  output logic                        wrStrobe
);
  import iepr_pkg::*;

  // Answer in the first access cycle; unmapped addresses flag an error
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !addrHit;
  assign wrStrobe = psel && penable && pwrite && addrHit;

  always_comb begin
    busReq.sel    = psel;
    busReq.enable = penable;
    busReq.write  = pwrite;
    busReq.addr   = paddr;
    busReq.wdata  = pwdata;
  end
endmodule

//--- hdl/iepr_regs.sv
/*
  Interrupt flag, enable and priority registers with request qualification.
  Assumes APB from the CPU side and one-cycle set pulses from peripherals;
  arbitration among the qualified requests lies outside.
*/
// Overview of operation
// - Enable bit gates each source request
// - Flag reads one after request, writable
// - Priority code 111 gives level 7
// - Priority 000 disables source completely
// - Nonzero codes map directly to levels
// - Unimplemented bits ignore writes, read zero
// - Priority register 0 field positions fixed
// - Enable register 0 upper bit order
// - Capture 8 and 7 enables bits 7,6
// - Change notify enable at bit 3
// - External pin 0 enable at bit 0
// - I2C slave bit 0, master bit 1
// - Priority fields reset to 100
module iepr_regs (
  // Clock and reset
  input  wire logic                                    core_clk,
  input  wire logic                                    reset,
  // APB
  input  wire logic                                    psel,
  input  wire logic                                    penable,
  input  wire logic                                    pwrite,
  input  wire logic [7:0]                              paddr,
  input  wire logic [31:0]                             pwdata,
  output logic [31:0]                                  prdata,
  output logic                                         pready,
  output logic                                         pslverr,
  // Peripheral events, one bit per source
  input  wire logic [iepr_pkg::NUM_SRC-1:0]            srcEvent,
  // Qualified requests to arbitration
  output iepr_pkg::iepr_req_t [iepr_pkg::NUM_SRC-1:0]  srcRequest,
  output logic                                         anyRequest
);
  import iepr_pkg::*;

  // Register bit position of each source in its flag/enable register
  localparam int BITPOS [NUM_SRC] = '{0, 1, 2, 3, 5, 6, 7, 8, 9, 10, 11, 12, 13,
                                      0, 1, 3, 4, 6, 7, 13, 1};
  // Register group: 0, 1 or 4
  localparam int GROUP  [NUM_SRC] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0,
                                      1, 1, 1, 1, 1, 1, 1, 4};
  // Priority register address and field low bit of each source
  localparam logic [7:0] PADDR [NUM_SRC] = '{OFF_PRI0, OFF_PRI0, OFF_PRI0, OFF_PRI0,
    OFF_PRI1, OFF_PRI1, OFF_PRI1, OFF_PRI2, OFF_PRI2, OFF_PRI2, OFF_PRI2, OFF_PRI3,
    OFF_PRI3, OFF_PRI4, OFF_PRI4, OFF_PRI4, OFF_PRI5, OFF_PRI5, OFF_PRI5, OFF_PRI7, OFF_PRI16};
  localparam int PLSB [NUM_SRC] = '{0, 4, 8, 12, 4, 8, 12, 0, 4, 8, 12, 0,
                                    4, 0, 4, 12, 0, 8, 12, 4, 4};
  // Priority registers 0..2 follow the fixed layout; 3 holds transmit and ADC

  iepr_apb_req_t                 busReq;
  logic                          wrStrobe;
  logic                          addrHit;
  logic [NUM_SRC-1:0]            flagVec;
  logic [NUM_SRC-1:0]            enVec;
  logic [PRIO_W-1:0]             prio_q [NUM_SRC];

  function automatic logic [7:0] flagAddr(input int grp);
    flagAddr = (grp == 0) ? OFF_FLAG0 : (grp == 1) ? OFF_FLAG1 : OFF_FLAG4;
  endfunction

  function automatic logic [7:0] enAddr(input int grp);
    enAddr = (grp == 0) ? OFF_EN0 : (grp == 1) ? OFF_EN1 : OFF_EN4;
  endfunction

  iepr_apb_slave u_apb (
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .addrHit  (addrHit),
    .busReq   (busReq),
    .wrStrobe (wrStrobe)
  );

  always_comb begin
    unique case (busReq.addr)
      OFF_FLAG0, OFF_FLAG1, OFF_FLAG4, OFF_EN0, OFF_EN1, OFF_EN4,
      OFF_PRI0, OFF_PRI1, OFF_PRI2, OFF_PRI3, OFF_PRI4, OFF_PRI5,
      OFF_PRI7, OFF_PRI16: addrHit = 1'b1;
      default:             addrHit = 1'b0;
    endcase
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
      logic flagWr;
      logic enWr;
      logic prioWr;
      // Only implemented positions get strobes; other bits stay inert
      assign flagWr = wrStrobe && (busReq.addr == flagAddr(GROUP[gi]));
      assign enWr   = wrStrobe && (busReq.addr == enAddr(GROUP[gi]));
      assign prioWr = wrStrobe && (busReq.addr == PADDR[gi]);

      always_ff @(posedge core_clk) begin
        if (reset) begin
          prio_q[gi] <= PRIO_RESET;
        end else if (prioWr) begin
          prio_q[gi] <= busReq.wdata[PLSB[gi] +: PRIO_W];
        end
      end

      iepr_src_cell u_cell (
        .core_clk  (core_clk),
        .reset     (reset),
        .evtSet    (srcEvent[gi]),
        .flagWr    (flagWr),
        .flagWrVal (busReq.wdata[BITPOS[gi]]),
        .enWr      (enWr),
        .enWrVal   (busReq.wdata[BITPOS[gi]]),
        .prio      (prio_q[gi]),
        .flag      (flagVec[gi]),
        .enable    (enVec[gi]),
        .request   (srcRequest[gi])
      );
    end
  endgenerate

  // Flags stay set until software clears them, so service must clear first
  always_comb begin
    anyRequest = 1'b0;
    for (int i = 0; i < NUM_SRC; i++) begin
      anyRequest = anyRequest | srcRequest[i].req;
    end
  end

  // Read mux: unimplemented bits return zero
  logic [15:0] rdWord;
  always_comb begin
    rdWord = 16'h0000;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (busReq.addr == flagAddr(GROUP[i])) begin
        rdWord[BITPOS[i]] = flagVec[i];
      end
      if (busReq.addr == enAddr(GROUP[i])) begin
        rdWord[BITPOS[i]] = enVec[i];
      end
      if (busReq.addr == PADDR[i]) begin
        rdWord[PLSB[i] +: PRIO_W] = prio_q[i];
      end
    end
  end

  // Read data registered at setup so it is stable in the access cycle
  logic [31:0] prdata_q;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      prdata_q <= 32'h00000000;
    end else if (busReq.sel && !busReq.enable && !busReq.write) begin
      prdata_q <= {16'h0000, rdWord};
    end
  end
  assign prdata = prdata_q;
endmodule

//--- test/iepr_periph_model.sv
/*
  Peripheral-side model: turns bench fire commands into one-cycle event pulses.
  Assumes commands change just after the rising edge.
*/
module iepr_periph_model (
  // Clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         reset,
  // Command and events
  input  wire logic [iepr_pkg::NUM_SRC-1:0] fireMask,
  output logic      [iepr_pkg::NUM_SRC-1:0] srcEvent
);
  timeunit 1ns;
  timeprecision 1ps;
  import iepr_pkg::*;
  // Pulses only; a held level would defeat a software clear
  always_ff @(posedge core_clk) begin
    srcEvent <= reset ? '0 : fireMask;
  end
endmodule

//--- test/iepr_checker.sv
/*
  Port assertions for the flag, enable and priority registers.
  Assumes binding to iepr_regs.
*/
module iepr_checker (
  // Clock and reset
  input wire logic                                        core_clk,
  input wire logic                                        reset,
  // APB
  input wire logic                                        psel,
  input wire logic                                        penable,
  input wire logic                                        pwrite,
  input wire logic [7:0]                                  paddr,
  input wire logic [31:0]                                 pwdata,
  input wire logic [31:0]                                 prdata,
  input wire logic                                        pready,
  input wire logic                                        pslverr,
  // Sources
  input wire logic [iepr_pkg::NUM_SRC-1:0]                srcEvent,
  input wire iepr_pkg::iepr_req_t [iepr_pkg::NUM_SRC-1:0] srcRequest,
  input wire logic                                        anyRequest
);
  timeunit 1ns;
  timeprecision 1ps;
  import iepr_pkg::*;
  logic               wr;
  logic               zeroLvl;
  logic [NUM_SRC-1:0] reqVec;
  assign wr = psel && penable && pwrite;
  always_comb begin
    zeroLvl = 1'b0;
    for (int k = 0; k < NUM_SRC; k++) begin
      reqVec[k] = srcRequest[k].req;
      zeroLvl |= srcRequest[k].req && srcRequest[k].level == PRIO_OFF;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_upper; prdata[31:16] == 16'h0000; endproperty
  a_upper: assert property (p_upper) else $error("upper read half not zero");
  property p_gap;
    psel && penable && !pwrite && paddr == OFF_PRI0 |-> (prdata & 32'h00008888) == 32'h00000000;
  endproperty
  a_gap: assert property (p_gap) else $error("priority gap bit reads one");
  property p_lvl; !zeroLvl; endproperty
  a_lvl: assert property (p_lvl) else $error("request at level zero");
  property p_any; anyRequest == (reqVec != '0); endproperty
  a_any: assert property (p_any) else $error("any request mismatch");
  property p_sticky; !$past(reset) && ($past(reqVec) & ~reqVec) != '0 |-> $past(wr); endproperty
  a_sticky: assert property (p_sticky) else $error("request dropped without write");
  property p_cause;
    !$past(reset) && reqVec != $past(reqVec) |-> $past(wr) || $past(srcEvent) != '0;
  endproperty
  a_cause: assert property (p_cause) else $error("request changed without cause");
  property p_ext0;
    wr && paddr == OFF_PRI0 ##1 reqVec[SRC_EXT0] |-> srcRequest[SRC_EXT0].level == $past(pwdata[2:0]);
  endproperty
  a_ext0: assert property (p_ext0) else $error("pin0 level wrong");
  property p_tmr1;
    wr && paddr == OFF_PRI0 ##1 reqVec[SRC_TMR1] |-> srcRequest[SRC_TMR1].level == $past(pwdata[14:12]);
  endproperty
  a_tmr1: assert property (p_tmr1) else $error("timer level wrong");
endmodule

bind iepr_regs iepr_checker iepr_checker_i (.core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .srcEvent, .srcRequest, .anyRequest);

//--- test/interrupt_enable_priority_regs_tb.sv
/*
  Self-checking bench for the flag, enable and priority registers.
  Assumes a zero-wait APB slave and the peripheral model.
*/
module interrupt_enable_priority_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import iepr_pkg::*;
  logic core_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, anyRequest, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [NUM_SRC-1:0] fireMask = '0, srcEvent;
  iepr_req_t [NUM_SRC-1:0] srcRequest;
  int n_errors = 0, checks_done = 0;
  iepr_regs iepr_regs_i (.core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .srcEvent, .srcRequest, .anyRequest);
  iepr_periph_model iepr_periph_model_i (.core_clk, .reset, .fireMask, .srcEvent);
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // Holds the request until pready is seen high; an idle edge after it keeps calls from overlapping
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rdchk(string what, logic [7:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(what, rd, e);
  endtask
  task automatic reqchk(string what, int k, logic [3:0] e);
    @(posedge core_clk);
    check(what, {28'h0, srcRequest[k]}, {28'h0, e});
  endtask
  task automatic fire(int k);
    fireMask[k] <= 1'b1;
    @(posedge core_clk);
    fireMask <= '0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic t_reset;
    rdchk("pri0", OFF_PRI0, 32'h4444);
    rdchk("pri1", OFF_PRI1, 32'h4440);
    rdchk("pri16", OFF_PRI16, 32'h0040);
    rdchk("flag0", OFF_FLAG0, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_map;
    apb(1'b1, OFF_EN0, 32'hFFFFFFFF);
    rdchk("en0", OFF_EN0, 32'h3FEF);
    apb(1'b1, OFF_EN1, 32'hFFFFFFFF);
    rdchk("en1", OFF_EN1, 32'h20DB);
    apb(1'b1, OFF_PRI0, 32'hFFFFFFFF);
    rdchk("pri0", OFF_PRI0, 32'h7777);
    apb(1'b1, OFF_FLAG4, 32'hFFFFFFFF);
    rdchk("flag4", OFF_FLAG4, 32'h0002);
    apb(1'b1, OFF_FLAG4, 32'h0);
    apb(1'b1, OFF_EN1, 32'h0);
    apb(1'b1, OFF_EN0, 32'h0);
    apb(1'b1, 8'hFC, 32'hFFFFFFFF);
    check("unmapped error", {31'h0, err}, 32'h1);
    rdchk("unmapped data", 8'hFC, 32'h0);
    $display("map test done");
  endtask
  task automatic t_event;
    fire(SRC_EXT0);
    rdchk("flag0", OFF_FLAG0, 32'h0001);
    reqchk("masked", SRC_EXT0, 4'h0);
    apb(1'b1, OFF_EN0, 32'h0001);
    reqchk("enabled", SRC_EXT0, 4'hF);
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, OFF_PRI0, c);
      reqchk("level", SRC_EXT0, c == 0 ? 4'h0 : {1'b1, 3'(c)});
    end
    apb(1'b1, OFF_FLAG0, 32'h0);
    reqchk("cleared", SRC_EXT0, 4'h0);
    // Timer field sits at the top of the first priority register
    apb(1'b1, OFF_EN0, 32'h0008);
    fire(SRC_TMR1);
    rdchk("tmr1 flag", OFF_FLAG0, 32'h0008);
    reqchk("tmr1 off", SRC_TMR1, 4'h0);
    apb(1'b1, OFF_PRI0, 32'h5000);
    reqchk("tmr1 level", SRC_TMR1, 4'hD);
    apb(1'b1, OFF_FLAG0, 32'h0);
    reqchk("tmr1 cleared", SRC_TMR1, 4'h0);
    $display("event test done");
  endtask
  task automatic t_serial;
    apb(1'b1, OFF_EN4, 32'h0002);
    fire(SRC_SERR);
    reqchk("serial", SRC_SERR, 4'hC);
    check("any", {31'h0, anyRequest}, 32'h1);
    apb(1'b1, OFF_FLAG4, 32'h0);
    reqchk("serial off", SRC_SERR, 4'h0);
    $display("serial test done");
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_map();
    t_event();
    t_serial();
    print_verdict();
  end
  // Tests need well under a thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    print_verdict();
  end
endmodule
